// *** verif/drb_bank_monitor.sv ***
// Assertion checker for the readback decoder and bank-select bank.
`timescale 1ns/1ns
module drb_bank_monitor (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               clk_en,
  input wire logic               word_valid,
  input wire drb_pkg::drb_word_s word_in,
  input wire logic               bit_strobe,
  input wire logic               frame_start,
  input wire logic [639:0]       input_value_bank_a,
  input wire logic [639:0]       input_value_bank_b,
  input wire logic [39:0]        bank_select,
  input wire logic [639:0]       conversion_value,
  input wire logic               serial_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire sf = clk_en && word_valid && word_in.mode == 2'h0;
  property p_bank0; sf && word_in.sel == 6'h06 |=> bank_select[7:0] == $past(word_in.data[7:0]); endproperty
  a_bank0: assert property (p_bank0) else $error("bank zero write lost");
  property p_bank4; sf && word_in.sel == 6'h0a |=> bank_select[39:32] == $past(word_in.data[7:0]); endproperty
  a_bank4: assert property (p_bank4) else $error("bank four write lost");
  property p_all; sf && word_in.sel == 6'h0b |=> bank_select == {5{$past(word_in.data[7:0])}}; endproperty
  a_all: assert property (p_all) else $error("block write wrong");
  property p_idle; !sf |=> $stable(bank_select); endproperty
  a_idle: assert property (p_idle) else $error("bank changed without command");
  property p_nop; sf && word_in.sel inside {6'h00, 6'h05} |=> $stable(bank_select); endproperty
  a_nop: assert property (p_nop) else $error("bank changed by nop or select");
  property p_conv0; clk_en |=> conversion_value[15:0] == ($past(bank_select[0]) ?
    $past(input_value_bank_b[15:0]) : $past(input_value_bank_a[15:0])); endproperty
  a_conv0: assert property (p_conv0) else $error("channel zero routing wrong");
  property p_conv39; clk_en |=> conversion_value[639:624] == ($past(bank_select[39]) ?
    $past(input_value_bank_b[639:624]) : $past(input_value_bank_a[639:624])); endproperty
  a_conv39: assert property (p_conv39) else $error("channel 39 routing wrong");
  property p_ser; !bit_strobe && !frame_start |=> $stable(serial_out); endproperty
  a_ser: assert property (p_ser) else $error("serial bit moved without strobe");
  c_read: cover property (sf && word_in.sel == 6'h05);
  c_all: cover property (sf && word_in.sel == 6'h0b);
  c_bit: cover property (bit_strobe);
endmodule
bind drb_bank drb_bank_monitor mon (.clk, .rst, .clk_en, .word_valid, .word_in, .bit_strobe, .frame_start,
  .input_value_bank_a, .input_value_bank_b, .bank_select, .conversion_value, .serial_out);

// *** verif/drb_host_model.sv ***
// Host model that issues command words and clocks readback frames.
`timescale 1ns/1ns
module drb_host_model (
  input  wire logic          clk,
  input  wire logic          serial_out,
  output drb_pkg::drb_word_s word_in,
  output logic               word_valid,
  output logic               frame_start,
  output logic               bit_strobe
);
  initial begin
    word_in = '0;
    word_valid = 1'b0;
    frame_start = 1'b0;
    bit_strobe = 1'b0;
  end
  task automatic send(input drb_pkg::drb_word_s w);
    @(posedge clk);
    word_valid <= 1'b1;
    word_in <= w;
    @(posedge clk);
    word_valid <= 1'b0;
    // Released word bus shows the inverse so stale data cannot pass.
    word_in <= ~w;
  endtask
  task automatic frame(output logic [23:0] q);
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    repeat (24) begin
      @(posedge clk);
      bit_strobe <= 1'b1;
      @(posedge clk);
      bit_strobe <= 1'b0;
      @(posedge clk);
      q = {q[22:0], serial_out};
    end
    send('0);
  endtask
endmodule

// *** verif/tb.sv ***
// Testbench for the readback decoder and bank-select bank.
`timescale 1ns/1ns
module tb;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               en = 1'b1;
  logic [639:0]       va, vb, vo, vg, conversion_value;
  logic [39:0]        bank_select;
  logic               serial_out, word_valid, frame_start, bit_strobe;
  drb_pkg::drb_word_s word_in;
  logic [23:0]        q;
  logic [7:0]         v;
  int                 errors = 0;
  int                 comparisons = 0;
  localparam logic [15:0] RA [10] = '{16'h8300, 16'h857f, 16'h8080, 16'h8100, 16'h8180, 16'h8200,
                                      16'h0400, 16'h37ff, 16'h4680, 16'h7400};
  localparam logic [15:0] RE [10] = '{16'h005a, 16'h00ce, 16'h0005, 16'h1234, 16'h2345, 16'h0000,
                                      16'h1000, 16'h2027, 16'h3005, 16'h4020};
  always #50 clk = ~clk;
  drb_bank dut (.clk, .rst, .clk_en(en), .word_valid, .word_in, .frame_start, .bit_strobe,
    .input_value_bank_a(va), .input_value_bank_b(vb), .offset_trim(vo), .gain_trim(vg),
    .control_value(16'h0005), .group_zero_offset_level(16'h1234), .group_one_offset_level(16'h2345),
    .bank_select, .conversion_value, .serial_out);
  drb_host_model host (.clk, .serial_out, .word_in, .word_valid, .frame_start, .bit_strobe);
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_misc();
    chk("reset", 40'h0, bank_select);
    host.send({2'h0, drb_pkg::SF_BANK_ALL, 16'h00c3});
    host.send({2'h1, drb_pkg::SF_BANK0, 16'h00ff});
    host.send({2'h0, drb_pkg::SF_NOP, 16'h0000});
    repeat (2) @(posedge clk);
    chk("block", {5{8'hc3}}, bank_select);
    en <= 1'b0;
    host.send({2'h0, drb_pkg::SF_BANK0, 16'h0011});
    repeat (2) @(posedge clk);
    chk("frozen", {5{8'hc3}}, bank_select);
    en <= 1'b1;
  endtask
  task automatic t_banks();
    for (int n = 0; n < 5; n++) begin
      v = 8'h5a ^ 8'(n * 37);
      host.send({2'h0, 6'h06 + 6'(n), 8'h00, v});
      repeat (3) @(posedge clk);
      chk("bank", 40'(v), 40'(bank_select[n*8+:8]));
      for (int c = n * 8; c < n * 8 + 8; c++)
        chk("conv", 40'(v[c%8] ? vb[c*16+:16] : va[c*16+:16]), 40'(conversion_value[c*16+:16]));
    end
  endtask
  task automatic t_read();
    for (int i = 0; i < 10; i++) begin
      host.send({2'h0, drb_pkg::SF_READBACK, RA[i]});
      host.frame(q);
      chk("readback", 40'(RE[i]), 40'(q));
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int c = 0; c < 40; c++) begin
      va[c*16+:16] = 16'h1000 + 16'(c);
      vb[c*16+:16] = 16'h2000 + 16'(c);
      vo[c*16+:16] = 16'h3000 + 16'(c);
      vg[c*16+:16] = 16'h4000 + 16'(c);
    end
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_misc();
    t_banks();
    t_read();
    close_out();
  end
  initial begin
    #500000;
    errors++;
    close_out();
  end
endmodule

// *** verilog/drb_bank.sv ***
// Readback decoder, bank-select registers and readback shifter.
`timescale 1ns/1ns
module drb_bank (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         clk_en,
  input  wire logic                         word_valid,
  input  wire drb_pkg::drb_word_s           word_in,
  input  wire logic                         frame_start,
  input  wire logic                         bit_strobe,
  input  wire logic [drb_pkg::NUM_CH*16-1:0] input_value_bank_a,
  input  wire logic [drb_pkg::NUM_CH*16-1:0] input_value_bank_b,
  input  wire logic [drb_pkg::NUM_CH*16-1:0] offset_trim,
  input  wire logic [drb_pkg::NUM_CH*16-1:0] gain_trim,
  input  wire logic [15:0]                  control_value,
  input  wire logic [15:0]                  group_zero_offset_level,
  input  wire logic [15:0]                  group_one_offset_level,
  output logic [drb_pkg::NUM_CH-1:0]        bank_select,
  output logic [drb_pkg::NUM_CH*16-1:0]     conversion_value,
  output logic                              serial_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [drb_pkg::NUM_BANK-1:0][7:0] bank_r, bank_nxt;
  logic [drb_pkg::NUM_CH*16-1:0]     conv_r, conv_nxt;
  logic [15:0]                       sel_r, sel_nxt;
  logic [23:0]                       shreg_r, shreg_nxt;
  logic [4:0]                        cnt_r, cnt_nxt;
  logic                              sout_r, sout_nxt;
  logic [15:0]                       rb_val;
  drb_pkg::drb_state_e               st_r, st_nxt;

  function automatic logic [15:0] pick(input logic [drb_pkg::NUM_CH*16-1:0] v, input logic [5:0] code);
    logic [5:0] idx;
    idx = code - drb_pkg::CH_FIRST;
    pick = v[idx*16 +: 16];
  endfunction

  // Decode of a held readback address into the register contents.
  function automatic logic [15:0] readback(
      input logic [15:0]                     a,
      input logic [drb_pkg::NUM_BANK-1:0][7:0] b,
      input logic [drb_pkg::NUM_CH*16-1:0]   xa,
      input logic [drb_pkg::NUM_CH*16-1:0]   xb,
      input logic [drb_pkg::NUM_CH*16-1:0]   oc,
      input logic [drb_pkg::NUM_CH*16-1:0]   gm,
      input logic [15:0]                     ctl,
      input logic [15:0]                     o0,
      input logic [15:0]                     o1);
    logic [2:0] cls;
    logic [5:0] code;
    logic [5:0] bi;
    readback = 16'h0000;
    cls  = a[15:13];
    code = a[12:7];
    bi   = code - drb_pkg::FIX_BANK0;
    if (cls <= drb_pkg::CLS_GAIN) begin
      if (code >= drb_pkg::CH_FIRST && code <= drb_pkg::CH_LAST) begin
        unique case (cls)
          drb_pkg::CLS_IN_A:   readback = pick(xa, code);
          drb_pkg::CLS_IN_B:   readback = pick(xb, code);
          drb_pkg::CLS_OFFSET: readback = pick(oc, code);
          default:             readback = pick(gm, code);
        endcase
      end
    end else if (cls == drb_pkg::CLS_FIXED) begin
      // Reserved and unknown codes read as zero rather than alias a real register.
      unique case (code)
        drb_pkg::FIX_CONTROL: begin
          readback = ctl;
        end
        drb_pkg::FIX_GROUP_ZERO_OFFSET_LEVEL: begin
          readback = o0;
        end
        drb_pkg::FIX_GROUP_ONE_OFFSET_LEVEL: begin
          readback = o1;
        end
        default: begin
          if (code >= drb_pkg::FIX_BANK0 && bi < 6'(drb_pkg::NUM_BANK)) begin
            readback = {8'h00, b[bi[2:0]]};
          end
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    bank_nxt = bank_r;
    sel_nxt  = sel_r;
    if (word_valid && word_in.mode == drb_pkg::MODE_SPECIAL) begin
      if (word_in.sel >= drb_pkg::SF_BANK0 && word_in.sel < drb_pkg::SF_BANK_ALL) begin
        bank_nxt[3'(word_in.sel - drb_pkg::SF_BANK0)] = word_in.data[7:0];
      end else if (word_in.sel == drb_pkg::SF_BANK_ALL) begin
        for (int n = 0; n < drb_pkg::NUM_BANK; n++) begin
          bank_nxt[n] = word_in.data[7:0];
        end
      end else if (word_in.sel == drb_pkg::SF_READBACK) begin
        sel_nxt = word_in.data;
      end
    end
  end

  for (genvar c = 0; c < drb_pkg::NUM_CH; c++) begin : g_route
    assign conv_nxt[c*16 +: 16] = bank_r[c/8][c%8] ? input_value_bank_b[c*16 +: 16]
                                                    : input_value_bank_a[c*16 +: 16];
  end

  // Readback contents of the latched address; read live so the frame sees current values.
  always_comb begin
    rb_val = readback(sel_r,
                      bank_r,
                      input_value_bank_a,
                      input_value_bank_b,
                      offset_trim,
                      gain_trim,
                      control_value,
                      group_zero_offset_level,
                      group_one_offset_level);
  end

  // Readback sequencer; the frame after the select always shifts, whatever it carries.
  always_comb begin
    st_nxt    = st_r;
    shreg_nxt = shreg_r;
    cnt_nxt   = cnt_r;
    sout_nxt  = sout_r;
    unique case (st_r)
      drb_pkg::DRB_IDLE: begin
        if (word_valid && word_in.mode == drb_pkg::MODE_SPECIAL && word_in.sel == drb_pkg::SF_READBACK) begin
          st_nxt = drb_pkg::DRB_ARMED;
        end
      end
      drb_pkg::DRB_ARMED: begin
        if (frame_start) begin
          // full frame, value low, MSB first
          shreg_nxt = {8'h00, rb_val};
          cnt_nxt   = 5'h00;
          sout_nxt  = 1'b0;
          st_nxt    = drb_pkg::DRB_SHIFT;
        end
      end
      drb_pkg::DRB_SHIFT: begin
        if (bit_strobe) begin
          sout_nxt  = shreg_r[23];
          shreg_nxt = {shreg_r[22:0], 1'b0};
          cnt_nxt   = cnt_r + 5'h01;
          if (cnt_r == drb_pkg::BIT_CNT_LAST) begin
            st_nxt = drb_pkg::DRB_IDLE;
          end
        end
      end
      default: st_nxt = drb_pkg::DRB_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank and address registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_r <= {drb_pkg::NUM_BANK{drb_pkg::BANK_RESET}};
      sel_r  <= 16'h0000;
    end else if (clk_en) begin
      bank_r <= bank_nxt;
      sel_r  <= sel_nxt;
    end
  end

  // Conversion routing register; one cycle behind the bank bits.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_r <= '0;
    end else if (clk_en) begin
      conv_r <= conv_nxt;
    end
  end

  // Readback sequencer registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shreg_r <= 24'h000000;
      cnt_r   <= 5'h00;
      sout_r  <= 1'b0;
      st_r    <= drb_pkg::DRB_IDLE;
    end else if (clk_en) begin
      shreg_r <= shreg_nxt;
      cnt_r   <= cnt_nxt;
      sout_r  <= sout_nxt;
      st_r    <= st_nxt;
    end
  end

  assign bank_select      = bank_r;
  assign conversion_value = conv_r;
  assign serial_out       = sout_r;
endmodule

// *** verilog/drb_pkg.sv ***
// Package with constants and carriers for the readback decoder and bank-select bank.
package drb_pkg;
  localparam int          WORD_W        = 24;
  localparam int          NUM_CH        = 40;
  localparam int          NUM_BANK      = 5;
  localparam int          DATA_W        = 16;
  localparam logic [1:0]  MODE_SPECIAL  = 2'h0;
  localparam logic [5:0]  SF_NOP        = 6'h00;
  localparam logic [5:0]  SF_CONTROL    = 6'h01;
  localparam logic [5:0]  SF_GROUP_ZERO_OFFSET_LEVEL       = 6'h02;
  localparam logic [5:0]  SF_GROUP_ONE_OFFSET_LEVEL       = 6'h03;
  localparam logic [5:0]  SF_READBACK   = 6'h05;
  localparam logic [5:0]  SF_BANK0      = 6'h06;
  localparam logic [5:0]  SF_BANK_ALL   = 6'h0b;
  localparam logic [2:0]  CLS_IN_A      = 3'h0;
  localparam logic [2:0]  CLS_IN_B      = 3'h1;
  localparam logic [2:0]  CLS_OFFSET    = 3'h2;
  localparam logic [2:0]  CLS_GAIN      = 3'h3;
  localparam logic [2:0]  CLS_FIXED     = 3'h4;
  localparam logic [5:0]  CH_FIRST      = 6'h08;
  localparam logic [5:0]  CH_LAST       = 6'h2f;
  localparam logic [5:0]  FIX_CONTROL   = 6'h01;
  localparam logic [5:0]  FIX_GROUP_ZERO_OFFSET_LEVEL      = 6'h02;
  localparam logic [5:0]  FIX_GROUP_ONE_OFFSET_LEVEL      = 6'h03;
  localparam logic [5:0]  FIX_BANK0     = 6'h06;
  localparam logic [7:0]  BANK_RESET    = 8'h00;
  localparam logic [4:0]  BIT_CNT_LAST  = 5'h17;

  typedef struct packed {
    logic [1:0]  mode;
    logic [5:0]  sel;
    logic [15:0] data;
  } drb_word_s;

  typedef enum logic [1:0] {
    DRB_IDLE  = 2'b00,
    DRB_ARMED = 2'b01,
    DRB_SHIFT = 2'b11
  } drb_state_e;
endpackage
